/* File: logic/aid_consts.vh */
// Constants for the accessory impedance detect sequencer
`ifndef AID_CONSTS_VH
`define AID_CONSTS_VH

// Detection mode encodings
`define AID_MODE_MIC_DISC   3'b000
`define AID_MODE_HP_LEFT    3'b001
`define AID_MODE_HP_RIGHT   3'b010
`define AID_MODE_HP_MICPIN  3'b100
`define AID_MODE_MIC_ADC    3'b111

// Reference select codes (00 is the always-on supply)
`define AID_REF_SUPPLY      2'b00

// Reset values
`define AID_LEVEL_MASK_RST  8'h9f
`define AID_STARTUP_RST     4'h1

// Timing: clock 10 MHz
`define AID_CLK_HZ          10000000
`define AID_QMS_US          250
`define AID_QMS_CYC         ((`AID_CLK_HZ / 1000000) * `AID_QMS_US)
`define AID_MEAS_MIN_US     100
`define AID_MEAS_MAX_US     500
`define AID_MEAS_MIN_CYC    ((`AID_CLK_HZ / 1000000) * `AID_MEAS_MIN_US)
`define AID_MEAS_MAX_CYC    ((`AID_CLK_HZ / 1000000) * `AID_MEAS_MAX_US)
`define AID_SWEEP_HZ        32000
`define AID_SWEEP_CYC       (`AID_CLK_HZ / `AID_SWEEP_HZ)
`define AID_STARTUP_MAXCODE 4'hc

// Headphone result: half-ohm steps, floor 8, ceiling 20000
`define AID_HP_FLOOR        15'h0008
`define AID_HP_CEIL         15'h4e20

`endif

/* File: logic/aid_tick_div.v */
// Programmable enable-pulse divider
`timescale 1ns/1ps
module aid_tick_div #(
    parameter WIDTH = 16
) (
    input  wire             mclk_i,
    input  wire             reset_n_i,
    input  wire             run_i,
    input  wire [WIDTH-1:0] period_i,
    output reg              tick_o
);
    reg [WIDTH-1:0] cnt_reg;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= {WIDTH{1'b0}};
            tick_o  <= 1'b0;
        end else if (!run_i) begin
            cnt_reg <= {WIDTH{1'b0}};
            tick_o  <= 1'b0;
        end else if (cnt_reg + 1'b1 >= period_i) begin
            cnt_reg <= {WIDTH{1'b0}};
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_o  <= 1'b0;
        end
    end
endmodule // aid_tick_div

/* File: logic/aid_detect.v */
// Accessory impedance detect sequencer: mic/button and headphone detection
`timescale 1ns/1ps
`include "aid_consts.vh"

module aid_detect #(
    parameter SWEEP_STEPS = 64
) (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        mic_detect_enable_i,
    input  wire [2:0]  detect_mode_select_i,
    input  wire        detect_pin_source_i,
    input  wire [1:0]  detect_reference_select_i,
    input  wire [2:0]  bias_n_enable_i,
    input  wire [3:0]  bias_startup_delay_i,
    input  wire [7:0]  level_enable_mask_i,
    input  wire        hp_measure_start_i,
    input  wire [1:0]  hp_sweep_clock_div_i,
    input  wire [2:0]  hp_ramp_hold_time_i,
    input  wire [1:0]  hp_range_select_i,
    input  wire        meas_done_i,
    input  wire [8:0]  meas_level_i,
    input  wire        hp_trip_i,
    output reg  [2:0]  bias_auto_on_o,
    output reg         mic_meas_start_o,
    output reg  [1:0]  sense_pin_sel_o,
    output reg  [8:0]  level_result_o,
    output reg         level_valid_o,
    output reg         hp_source_step_o,
    output reg  [7:0]  hp_source_code_o,
    output reg  [1:0]  hp_range_o,
    output reg         hp_measure_done_o,
    output reg  [14:0] hp_impedance_result_o,
    output reg         hp_measure_done_event_o,
    output reg         hp_gpio_o
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_BIAS  = 3'd1;
    localparam ST_MEAS  = 3'd2;
    localparam ST_HPUP  = 3'd3;
    localparam ST_HPHLD = 3'd4;
    localparam ST_HPDN  = 3'd5;

    // Sized copies of the timing counts, cut by part-select where used
    localparam [31:0] QMS_CYC    = `AID_QMS_CYC;
    localparam [31:0] MEAS_MIN   = `AID_MEAS_MIN_CYC;
    localparam [31:0] MEAS_MAX   = `AID_MEAS_MAX_CYC;
    localparam [31:0] SWEEP_CYC  = `AID_SWEEP_CYC;
    localparam [31:0] SWEEP_LAST = SWEEP_STEPS - 1;

    // Analog comparator and result come from another domain
    reg        done_s1_reg, done_s2_reg;
    reg        trip_s1_reg, trip_s2_reg;
    reg [8:0]  lvl_s1_reg, lvl_s2_reg;

    reg [2:0]  state_reg;
    reg [22:0] wait_reg;
    reg [12:0] step_cnt_reg;
    reg [7:0]  code_reg;
    reg [14:0] hp_impedance_result_reg;
    reg        tick_run;
    reg [15:0] tick_period;
    wire       sweep_tick;

    // Start-up delay in cycles, 0 for code 0, doubles per code step from code 1 up to code 12
    function [22:0] startup_cycles;
        input [3:0] code;
        reg   [3:0] c;
        begin
            c = (code >= `AID_STARTUP_MAXCODE) ? `AID_STARTUP_MAXCODE : code;
            if (c == 4'h0)
                startup_cycles = 23'h00_0000;
            else
                startup_cycles = QMS_CYC[22:0] << (c - 4'h1);
        end
    endfunction

    // Hold time in sweep clocks
    function [12:0] hold_clocks;
        input [2:0] code;
        begin
            case (code)
                3'd0:    hold_clocks = 13'h0001;
                3'd1:    hold_clocks = 13'h0004;
                3'd2:    hold_clocks = 13'h0010;
                3'd3:    hold_clocks = 13'h0040;
                3'd4:    hold_clocks = 13'h0100;
                3'd5:    hold_clocks = 13'h0200;
                3'd6:    hold_clocks = 13'h0300;
                default: hold_clocks = 13'h0400;
            endcase
        end
    endfunction

    // Highest enabled level at or below the raw one; bit 0 is always <3 ohm
    function [8:0] fold_level;
        input [8:0] raw;
        input [7:0] mask;
        integer     i;
        reg         found;
        reg   [8:0] r;
        begin
            r          = raw;
            fold_level = 9'h001;
            found      = 1'b0;
            for (i = 8; i >= 1; i = i - 1) begin
                if (!found && r[i] && mask[i-1]) begin
                    fold_level = 9'h001 << i;
                    found      = 1'b1;
                end else if (!found && r[i]) begin
                    r[i-1] = 1'b1;
                end
            end
        end
    endfunction

    wire [1:0] ref_idx   = detect_reference_select_i - 2'd1;
    wire       ref_bias  = detect_reference_select_i != `AID_REF_SUPPLY;
    wire       sw_bias   = ref_bias && bias_n_enable_i[ref_idx];
    wire       mode_mic  = detect_mode_select_i == `AID_MODE_MIC_DISC;
    wire       mode_hp   = detect_mode_select_i == `AID_MODE_HP_LEFT
                        || detect_mode_select_i == `AID_MODE_HP_RIGHT
                        || detect_mode_select_i == `AID_MODE_HP_MICPIN;

    always @* begin
        tick_run    = state_reg == ST_HPUP || state_reg == ST_HPHLD || state_reg == ST_HPDN;
        // Divider code doubles the period
        tick_period = SWEEP_CYC[15:0] << hp_sweep_clock_div_i;
    end

    aid_tick_div #(.WIDTH(16)) u_sweep (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .run_i     (tick_run),
        .period_i  (tick_period),
        .tick_o    (sweep_tick)
    );

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            trip_s1_reg <= 1'b0;
            trip_s2_reg <= 1'b0;
            lvl_s1_reg  <= 9'h000;
            lvl_s2_reg  <= 9'h000;
        end else begin
            done_s1_reg <= meas_done_i;
            done_s2_reg <= done_s1_reg;
            trip_s1_reg <= hp_trip_i;
            trip_s2_reg <= trip_s1_reg;
            lvl_s1_reg  <= meas_level_i;
            lvl_s2_reg  <= lvl_s1_reg;
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg             <= ST_IDLE;
            wait_reg              <= 23'h00_0000;
            step_cnt_reg          <= 13'h0000;
            code_reg              <= 8'h00;
            hp_impedance_result_reg            <= 15'h0000;
            bias_auto_on_o        <= 3'b000;
            mic_meas_start_o      <= 1'b0;
            sense_pin_sel_o       <= 2'b00;
            level_result_o        <= 9'h000;
            level_valid_o         <= 1'b0;
            hp_source_step_o      <= 1'b0;
            hp_source_code_o      <= 8'h00;
            hp_range_o            <= 2'b00;
            hp_measure_done_o     <= 1'b0;
            hp_impedance_result_o <= 15'h0000;
            hp_measure_done_event_o       <= 1'b0;
            hp_gpio_o             <= 1'b0;
        end else begin
            mic_meas_start_o <= 1'b0;
            hp_source_step_o <= 1'b0;
            hp_measure_done_event_o  <= 1'b0;
            // Pin choice: 0 or 3 first or second mic pin, 1 left, 2 right
            case (detect_mode_select_i)
                `AID_MODE_HP_LEFT:  sense_pin_sel_o <= 2'd1;
                `AID_MODE_HP_RIGHT: sense_pin_sel_o <= 2'd2;
                default:            sense_pin_sel_o <= detect_pin_source_i ? 2'd3 : 2'd0;
            endcase
            hp_range_o <= hp_range_select_i;
            // Start clears done; taken only in idle, so a start in the done cycle is lost
            if (hp_measure_start_i && mode_hp && state_reg == ST_IDLE) begin
                hp_measure_done_o <= 1'b0;
                hp_gpio_o         <= 1'b1;
                code_reg          <= 8'h00;
                state_reg         <= ST_HPUP;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (mic_detect_enable_i && mode_mic) begin
                            if (ref_bias && !sw_bias) begin
                                bias_auto_on_o <= 3'b001 << ref_idx;
                                wait_reg  <= startup_cycles(bias_startup_delay_i);
                                state_reg <= ST_BIAS;
                            end else begin
                                mic_meas_start_o <= 1'b1;
                                wait_reg  <= 23'h00_0000;
                                state_reg <= ST_MEAS;
                            end
                        end
                    end
                    ST_BIAS: begin
                        if (wait_reg == 23'h00_0000) begin
                            mic_meas_start_o <= 1'b1;
                            state_reg        <= ST_MEAS;
                        end else begin
                            wait_reg <= wait_reg - 23'h00_0001;
                        end
                    end
                    ST_MEAS: begin
                        wait_reg <= wait_reg + 23'h00_0001;
                        // Front end sets duration; clamp to window
                        if ((done_s2_reg && wait_reg >= MEAS_MIN[22:0])
                            || wait_reg >= MEAS_MAX[22:0]) begin
                            level_result_o <= fold_level(lvl_s2_reg, level_enable_mask_i);
                            level_valid_o  <= 1'b1;
                            bias_auto_on_o <= 3'b000;
                            state_reg      <= ST_IDLE;
                        end
                    end
                    ST_HPUP: begin
                        if (sweep_tick) begin
                            hp_source_step_o <= 1'b1;
                            if (trip_s2_reg || code_reg == SWEEP_LAST[7:0]) begin
                                step_cnt_reg <= hold_clocks(hp_ramp_hold_time_i);
                                state_reg    <= ST_HPHLD;
                            end else begin
                                code_reg         <= code_reg + 8'h01;
                                hp_source_code_o <= code_reg + 8'h01;
                            end
                        end
                    end
                    ST_HPHLD: begin
                        if (sweep_tick) begin
                            if (step_cnt_reg <= 13'h0001)
                                state_reg <= ST_HPDN;
                            else
                                step_cnt_reg <= step_cnt_reg - 13'h0001;
                        end
                    end
                    ST_HPDN: begin
                        if (sweep_tick) begin
                            hp_source_step_o <= 1'b1;
                            if (hp_source_code_o == 8'h00) begin
                                hp_measure_done_o     <= 1'b1;
                                hp_impedance_result_o <= hp_impedance_result_reg;
                                hp_measure_done_event_o       <= 1'b1;
                                hp_gpio_o             <= 1'b0;
                                state_reg             <= ST_IDLE;
                            end else begin
                                hp_source_code_o <= hp_source_code_o - 8'h01;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
            // Trip code scales across range, clamped to floor; the ceiling test compares the unscaled code plus 8
            if (state_reg == ST_HPHLD) begin
                if ({7'h00, code_reg} + 15'h0008 > `AID_HP_CEIL)
                    hp_impedance_result_reg <= `AID_HP_CEIL;
                else
                    hp_impedance_result_reg <= (({7'h00, code_reg} << {hp_range_o, 1'b0}) < `AID_HP_FLOOR)
                                ? `AID_HP_FLOOR
                                : ({7'h00, code_reg} << {hp_range_o, 1'b0});
            end
        end
    end
endmodule // aid_detect

/* File: verif/aid_detect_assertions.sv */
// Checker bound to the accessory impedance detect sequencer
`timescale 1ns/1ps
`include "aid_consts.vh"
module aid_detect_assertions (
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic [2:0]  detect_mode_select_i,
    input wire logic [1:0]  detect_reference_select_i,
    input wire logic [2:0]  bias_n_enable_i,
    input wire logic [3:0]  bias_startup_delay_i,
    input wire logic [7:0]  level_enable_mask_i,
    input wire logic        hp_measure_start_i,
    input wire logic [1:0]  hp_sweep_clock_div_i,
    input wire logic [2:0]  bias_auto_on_o,
    input wire logic        mic_meas_start_o,
    input wire logic [8:0]  level_result_o,
    input wire logic        hp_source_step_o,
    input wire logic        hp_measure_done_o,
    input wire logic [14:0] hp_impedance_result_o,
    input wire logic        hp_measure_done_event_o,
    input wire logic        hp_gpio_o
);
    logic [23:0] su_cyc;
    logic [23:0] bias_cnt_reg;
    logic [15:0] gap_reg;
    logic        seen_reg;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // Codes 12 and up all give the longest wait
    assign su_cyc = (bias_startup_delay_i == 4'h0) ? 24'h00_0000 :
        (bias_startup_delay_i >= `AID_STARTUP_MAXCODE) ? 24'(`AID_QMS_CYC << 11) :
        24'(`AID_QMS_CYC << (bias_startup_delay_i - 4'h1));
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bias_cnt_reg <= 24'h00_0000;
            gap_reg      <= 16'h0000;
            seen_reg     <= 1'h0;
        end else begin
            bias_cnt_reg <= (bias_auto_on_o == 3'h0) ? 24'h00_0000 : bias_cnt_reg + 24'h00_0001;
            gap_reg      <= hp_source_step_o ? 16'h0000 : gap_reg + 16'h0001;
            // First step of a run has no reference point
            seen_reg     <= hp_gpio_o && (seen_reg || hp_source_step_o);
        end
    end
    sequence s_hp_go;
        hp_measure_start_i && !hp_gpio_o && detect_mode_select_i inside {3'h1, 3'h2, 3'h4};
    endsequence
    sequence s_hp_busy;
        !hp_measure_done_o && hp_gpio_o;
    endsequence
    a_hp_start: assert property (s_hp_go |=> s_hp_busy)
        else $error("headphone start not taken");
    a_done_hold: assert property (hp_measure_done_o && !hp_measure_start_i |=> hp_measure_done_o)
        else $error("done flag dropped");
    a_done_event: assert property ($rose(hp_measure_done_o) |-> hp_measure_done_event_o && !hp_gpio_o)
        else $error("no completion event");
    a_event_pulse: assert property (hp_measure_done_event_o |-> hp_measure_done_o ##1 !hp_measure_done_event_o)
        else $error("event not a single pulse");
    a_bias_select: assert property (bias_auto_on_o != 3'h0 |-> (bias_auto_on_o & bias_n_enable_i) == 3'h0
        && bias_auto_on_o == (3'h1 << (detect_reference_select_i - 2'h1)))
        else $error("wrong bias powered");
    // Start pulse is launched one cycle after the full delay has run
    a_startup_wait: assert property (mic_meas_start_o && bias_auto_on_o != 3'h0 |-> bias_cnt_reg == su_cyc + 24'h00_0001)
        else $error("start-up delay wrong");
    a_mic_alone: assert property (mic_meas_start_o |-> !hp_gpio_o && detect_mode_select_i == 3'h0)
        else $error("mic detect in wrong mode");
    a_step_rate: assert property (hp_source_step_o && seen_reg |-> (32'(gap_reg) + 1) % (`AID_SWEEP_CYC << hp_sweep_clock_div_i) == 0)
        else $error("sweep step spacing wrong");
    a_level_fold: assert property ($changed(level_result_o) |-> $onehot(level_result_o)
        && (level_result_o[8:1] & ~level_enable_mask_i) == 8'h00)
        else $error("result in disabled level");
    a_hp_clamp: assert property (hp_measure_done_o |-> hp_impedance_result_o >= `AID_HP_FLOOR
        && hp_impedance_result_o <= `AID_HP_CEIL)
        else $error("impedance out of span");
endmodule // aid_detect_assertions

bind aid_detect aid_detect_assertions aid_detect_assertions_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .detect_mode_select_i(detect_mode_select_i),
    .detect_reference_select_i(detect_reference_select_i), .bias_n_enable_i(bias_n_enable_i),
    .bias_startup_delay_i(bias_startup_delay_i), .level_enable_mask_i(level_enable_mask_i),
    .hp_measure_start_i(hp_measure_start_i), .hp_sweep_clock_div_i(hp_sweep_clock_div_i),
    .bias_auto_on_o(bias_auto_on_o), .mic_meas_start_o(mic_meas_start_o),
    .level_result_o(level_result_o), .hp_source_step_o(hp_source_step_o),
    .hp_measure_done_o(hp_measure_done_o), .hp_impedance_result_o(hp_impedance_result_o),
    .hp_measure_done_event_o(hp_measure_done_event_o), .hp_gpio_o(hp_gpio_o)
);

/* File: verif/aid_analog_model.sv */
// Behavioural analog front end: mic level measurement and headphone comparator
`timescale 1ns/1ps
module aid_analog_model (
    input  wire logic       mclk_i,
    input  wire logic       meas_start_i,
    input  wire logic [8:0] level_i,
    input  wire logic [7:0] code_i,
    input  wire logic [7:0] trip_code_i,
    input  wire logic       sweep_on_i,
    output logic            meas_done_o,
    output logic      [8:0] meas_level_o,
    output logic            hp_trip_o
);
    int wait_cnt = -1;
    int delay;
    initial meas_done_o = 1'h0;
    initial meas_level_o = 9'h000;
    // 1100 to 1900 cycles, higher impedance finishes sooner
    always_comb begin
        delay = 1900;
        for (int k = 0; k < 9; k++) if (level_i[k]) delay = 1900 - 100 * k;
    end
    always @(posedge mclk_i) begin
        if (meas_start_i) begin
            meas_done_o  <= 1'h0;
            meas_level_o <= ~level_i; // Lines unsettled while measuring
            wait_cnt     <= delay;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
            if (wait_cnt == 2) meas_level_o <= level_i;
        end else if (wait_cnt == 0) begin
            meas_done_o <= 1'h1;
            wait_cnt    <= -1;
        end
    end
    assign hp_trip_o = sweep_on_i && (code_i >= trip_code_i);
endmodule // aid_analog_model

/* File: verif/aid_detect_bench.sv */
// Self-checking bench for the accessory impedance detect sequencer
`timescale 1ns/1ps
`include "aid_consts.vh"
module aid_detect_bench;
    typedef struct packed {logic [8:0] raw; logic [7:0] mask; logic [8:0] res;} aid_mic_row_t;
    typedef struct packed {logic [2:0] mode; logic [1:0] range, div, pin;
        logic [7:0] trip; logic [14:0] res;} aid_hp_row_t;
    aid_mic_row_t mic_rows [8] = '{'{9'h100, 8'h9f, 9'h100}, '{9'h100, 8'h1f, 9'h020},
        '{9'h008, 8'h9b, 9'h004}, '{9'h002, 8'h9e, 9'h001}, '{9'h001, 8'h00, 9'h001},
        '{9'h020, 8'h8f, 9'h010}, '{9'h010, 8'h9f, 9'h010}, '{9'h004, 8'h80, 9'h001}};
    aid_hp_row_t hp_rows [3] = '{'{3'h1, 2'h2, 2'h0, 2'h1, 8'h05, 15'h0050},
        '{3'h2, 2'h0, 2'h1, 2'h2, 8'h01, 15'h0008}, '{3'h4, 2'h3, 2'h0, 2'h3, 8'h07, 15'h01c0}};
    logic        mclk_i = 1'h0, reset_n_i = 1'h0, mic_en = 1'h0, hp_start = 1'h0;
    logic [2:0]  mode = 3'h0, bias_en = 3'h0;
    logic [1:0]  ref_sel = 2'h0, hp_div = 2'h0, hp_range = 2'h0;
    logic        pin_src = 1'h0;
    logic [3:0]  su_delay = 4'h1; // Fast ramp assumed
    logic [7:0]  mask = 8'h9f, trip_code = 8'hff;
    logic [8:0]  lvl = 9'h100;
    wire         meas_done, hp_trip, mic_start, lvl_valid, step, done, evt, gpio;
    wire  [8:0]  meas_level, lvl_res;
    wire  [2:0]  bias_auto;
    wire  [1:0]  pin_sel, range_o;
    wire  [7:0]  code;
    wire  [14:0] hp_res;
    int          n_fail = 0, comparisons = 0, cyc = 0, k, n_step = 0;
    aid_detect #(.SWEEP_STEPS(8)) aid_detect_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .mic_detect_enable_i(mic_en), .detect_mode_select_i(mode), .detect_pin_source_i(pin_src),
        .detect_reference_select_i(ref_sel), .bias_n_enable_i(bias_en),
        .bias_startup_delay_i(su_delay), .level_enable_mask_i(mask),
        .hp_measure_start_i(hp_start), .hp_sweep_clock_div_i(hp_div),
        .hp_ramp_hold_time_i(3'h0), .hp_range_select_i(hp_range), .meas_done_i(meas_done),
        .meas_level_i(meas_level), .hp_trip_i(hp_trip), .bias_auto_on_o(bias_auto),
        .mic_meas_start_o(mic_start), .sense_pin_sel_o(pin_sel), .level_result_o(lvl_res),
        .level_valid_o(lvl_valid), .hp_source_step_o(step), .hp_source_code_o(code),
        .hp_range_o(range_o), .hp_measure_done_o(done), .hp_impedance_result_o(hp_res),
        .hp_measure_done_event_o(evt), .hp_gpio_o(gpio));
    aid_analog_model aid_analog_model_inst (.mclk_i(mclk_i), .meas_start_i(mic_start),
        .level_i(lvl), .code_i(code), .trip_code_i(trip_code), .sweep_on_i(gpio),
        .meas_done_o(meas_done), .meas_level_o(meas_level), .hp_trip_o(hp_trip));
    always #50 mclk_i = ~mclk_i;
    // Counts the sweep steps of one headphone run
    always @(posedge mclk_i) if (step === 1'h1) n_step++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // Longest path is about 53000 cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        cycles(16);
        reset_n_i = 1'h1;
        check(32'({done, lvl_valid, gpio, lvl_res, hp_res}), 32'h0);
        cycles(2);
        mic_en = 1'h1;
        foreach (mic_rows[i]) begin
            mask = mic_rows[i].mask;
            lvl = mic_rows[i].raw;
            for (k = 0; k < 6000 && mic_start !== 1'h1; k++) @(negedge mclk_i);
            cycles(2100);
            check(32'({lvl_valid, lvl_res}), 32'({1'h1, mic_rows[i].res}));
        end
        mic_en = 1'h0;
        cycles(5100);
        ref_sel = 2'h1; // Bias left to the auto window, discharge off
        mic_en = 1'h1;
        for (k = 0; k < 100 && bias_auto === 3'h0; k++) @(negedge mclk_i);
        check(32'(bias_auto), 32'h1);
        for (k = 0; k < 3000 && mic_start !== 1'h1; k++) @(negedge mclk_i);
        // Start pulse comes one cycle after the delay has run out
        check(32'(k), 32'(`AID_QMS_CYC + 1));
        mic_en = 1'h0;
        cycles(5100);
        bias_en = 3'h1;
        mic_en = 1'h1;
        for (k = 0; k < 100 && mic_start !== 1'h1; k++) @(negedge mclk_i);
        check(32'({mic_start, bias_auto}), 32'h8);
        check(32'(pin_sel), 32'h0);
        mic_en = 1'h0;
        cycles(5100);
        bias_en = 3'h0; // Mic pin bias floats during headphone detect
        mode = hp_rows[0].mode;
        mic_en = 1'h1; // Must stay ignored outside mic mode
        foreach (hp_rows[i]) begin
            mode = hp_rows[i].mode;
            hp_range = hp_rows[i].range; // Range 2 first, then 0 and 3
            hp_div = hp_rows[i].div;
            trip_code = hp_rows[i].trip;
            pin_src = (hp_rows[i].mode == 3'h4);
            cycles(2);
            n_step = 0;
            hp_start = 1'h1; // Drivers off, hold time default
            @(negedge mclk_i) hp_start = 1'h0;
            check(32'({done, gpio, pin_sel, range_o}),
                32'({2'h1, hp_rows[i].pin, hp_rows[i].range}));
            if (i == 0) begin
                cycles(20);
                hp_start = 1'h1; // Start while busy is refused
                @(negedge mclk_i) hp_start = 1'h0;
            end
            for (k = 0; k < 20000 && done !== 1'h1; k++) @(negedge mclk_i);
            check(32'({evt, gpio, hp_res}), 32'({2'h2, hp_rows[i].res}));
            cycles(50);
            check(32'({done, gpio}), 32'h2);
            check(32'(code), 32'h0);
            // Up to the trip code and back down, one step per sweep clock
            check(32'(n_step), 32'(2 * (hp_rows[i].trip + 1)));
        end
        mode = 3'h0;
        test_done();
    end
endmodule // aid_detect_bench
